/* design/plsc_pkg.sv */
// package for the loopback and strap configuration block: register map,
// field positions, strap codes, presets and timing counts.
// assumes a single 25 mhz core clock and 32-bit apb register access.
package plsc_pkg;

  // register indexes as numbered by software, byte address is index * 4
  localparam int          REG_CTRL_IDX     = 0;
  localparam int          REG_ADV_IDX      = 4;
  localparam int          REG_SPEC_IDX     = 17;
  localparam int          REG_MODES_IDX    = 18;
  localparam logic [7:0]  REG_CTRL_ADDR    = 8'(REG_CTRL_IDX * 4);
  localparam logic [7:0]  REG_ADV_ADDR     = 8'(REG_ADV_IDX * 4);
  localparam logic [7:0]  REG_SPEC_ADDR    = 8'(REG_SPEC_IDX * 4);
  localparam logic [7:0]  REG_MODES_ADDR   = 8'(REG_MODES_IDX * 4);

  // control register fields
  localparam int          CTRL_SRST_BIT    = 15;
  localparam int          CTRL_LOOP_BIT    = 14;
  localparam int          CTRL_SPEED_BIT   = 13;
  localparam int          CTRL_AN_BIT      = 12;
  localparam int          CTRL_PDOWN_BIT   = 11;
  localparam int          CTRL_ISO_BIT     = 10;
  localparam int          CTRL_DUPLEX_BIT  = 8;
  localparam int          CTRL_COLTEST_BIT = 7;
  // advertisement field, special control and special modes fields
  localparam int          ADV_LSB          = 5;
  localparam int          SPEC_FAR_BIT     = 9;
  localparam int          SPEC_BYPASS_BIT  = 3;
  localparam int          MODES_MODE_LSB   = 5;
  localparam int          MODES_ADDR_LSB   = 0;

  // strap codes with behaviour beyond plain presets
  localparam logic [2:0]  MODE_REPEATER    = 3'h5;
  localparam logic [2:0]  MODE_PDOWN       = 3'h6;
  localparam logic [3:0]  ADV_NONE_PRESET  = 4'hf;   // advert field left open in fixed modes
  localparam logic [5:0]  SCR_SEED_HI      = 6'h2b;  // keeps the scrambler seed nonzero

  // timing: core clock, soft reset length, external reset hold time
  localparam int          CLK_PERIOD_NS    = 40;
  localparam int          SRST_TIME_NS     = 400;
  localparam int          SRST_CYCLES      = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          HWRST_MIN_US     = 100;

  // control presets {speed, autoneg, isolate, duplex} per strap code
  function automatic logic [3:0] preset_ctrl(input logic [2:0] mode);
    logic [3:0] v;
    v = 4'h0;
    case (mode)
      3'h1:    v = 4'h1;
      3'h2:    v = 4'h8;
      3'h3:    v = 4'h9;
      3'h4:    v = 4'hc;
      3'h5:    v = 4'hc;
      3'h7:    v = 4'hd;
      default: v = 4'h0;
    endcase
    return v;
  endfunction

  // advertised abilities preset per strap code
  function automatic logic [3:0] preset_adv(input logic [2:0] mode);
    logic [3:0] v;
    v = ADV_NONE_PRESET;
    if (mode == 3'h4 || mode == 3'h5) begin
      v = 4'h4;
    end
    return v;
  endfunction

endpackage

/* design/plsc_phy_cfg.sv */
// phy loopback paths, strap capture, soft reset and apb register file.
// assumes apb on clk_in, straps pulled on the shared receive pins during reset,
// line side symbols already descrambled on input.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module plsc_phy_cfg #(
  parameter int SRST_CYCLES = plsc_pkg::SRST_CYCLES
) (
  input  wire logic        clk_in,                 // 25 mhz core clock
  input  wire logic        rstn_in,                // hardware reset, active low
  input  wire logic        ce_in,                  // clock enable, freezes state
  input  wire logic        apb_psel_in,            // apb select
  input  wire logic        apb_penable_in,         // apb access phase
  input  wire logic        apb_pwrite_in,          // apb write
  input  wire logic [7:0]  apb_paddr_in,           // apb byte address
  input  wire logic [31:0] apb_pwdata_in,          // apb write data
  output logic      [31:0] apb_prdata_out,         // apb read data
  output logic             apb_pready_out,         // apb ready
  output logic             apb_pslverr_out,        // unmapped address
  input  wire logic [1:0]  mac_txd_in,             // mac transmit data
  input  wire logic        mac_tx_en_in,           // mac transmit enable
  input  wire logic [1:0]  rxd_in,                 // rxd pin level, mode[1:0]
  output logic      [1:0]  rxd_out,                // receive data
  output logic             rxd_oe_out,             // rxd pin drive enable
  input  wire logic        crs_dv_in,              // crs_dv pin level, mode[2]
  output logic             crs_dv_out,             // carrier / data valid
  output logic             crs_dv_oe_out,          // crs_dv pin drive enable
  input  wire logic        addr_strap_bit_in,      // receive error pin level
  output logic             rx_er_out,              // receive error
  output logic             rx_er_oe_out,           // receive error pin drive enable
  output logic             col_out,                // collision
  input  wire logic [1:0]  line_rxd_in,            // descrambled line symbols
  input  wire logic        line_rx_dv_in,          // line receive activity
  input  wire logic        line_rx_er_in,          // line symbol error
  output logic      [1:0]  line_txd_out,           // scrambled line data
  output logic             line_tx_en_out,         // line transmitter power
  input  wire logic        mgmt_valid_in,          // management frame header seen
  input  wire logic [4:0]  mgmt_addr_in,           // frame phy address field
  input  wire logic        mgmt_write_in,          // frame is a write
  output logic             mgmt_accept_out,        // frame is for this phy
  output logic      [4:0]  phy_addr_out,           // current phy address
  output logic             pdown_out               // digital block powered down
);

  if (SRST_CYCLES < 1 || SRST_CYCLES > 1000) begin : g_bad_srst
    $error("SRST_CYCLES must be 1 to 1000");
  end

  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SRST} plsc_state_t;

  logic              rst_sync1_reg, rst_n_reg;
  plsc_state_t       state_reg;
  logic [9:0]        srst_cnt_reg;
  logic              loop_reg, speed_reg, an_reg, pdown_reg, iso_reg, duplex_reg, coltest_reg;
  logic [3:0]        adv_reg;
  logic              far_reg, bypass_reg;
  logic [2:0]        mode_reg;
  logic [4:0]        addr_reg;
  logic [10:0]       lfsr_reg;
  logic [1:0]        scr_data_reg, key_reg;
  logic              tx_en_q_reg;
  logic [31:0]       prdata_reg;
  logic              capture, srst_done, load_evt, setup, access, hit;
  logic              wr_ctrl, wr_adv, wr_spec, wr_modes;
  logic [2:0]        load_mode, strap_mode;
  logic [3:0]        pre_ctrl;
  logic              near_act, far_act, mac_quiet, tx_en_eff, half_tx_crs;
  logic [1:0]        txd_eff;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg     <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg     <= rst_sync1_reg;
    end
  end

  // strap pin map: rxd0, rxd1, crs_dv form the mode code
  assign strap_mode = {crs_dv_in, rxd_in};
  // gated by the released reset so the held state never reads as a capture
  assign capture    = ce_in && rst_n_reg && state_reg == ST_HOLD;
  assign srst_done  = ce_in && state_reg == ST_SRST && srst_cnt_reg == 10'h000;
  assign load_evt   = capture || srst_done;
  // soft reset takes presets from the mode field, never from the pins
  assign load_mode  = capture ? strap_mode : mode_reg;
  assign pre_ctrl   = plsc_pkg::preset_ctrl(load_mode);

  // apb decode
  assign setup    = apb_psel_in && !apb_penable_in;
  assign access   = apb_psel_in && apb_penable_in;
  assign hit      = apb_paddr_in == plsc_pkg::REG_CTRL_ADDR || apb_paddr_in == plsc_pkg::REG_ADV_ADDR ||
                    apb_paddr_in == plsc_pkg::REG_SPEC_ADDR || apb_paddr_in == plsc_pkg::REG_MODES_ADDR;
  assign wr_ctrl  = ce_in && access && apb_pwrite_in && apb_paddr_in == plsc_pkg::REG_CTRL_ADDR;
  assign wr_adv   = ce_in && access && apb_pwrite_in && apb_paddr_in == plsc_pkg::REG_ADV_ADDR;
  assign wr_spec  = ce_in && access && apb_pwrite_in && apb_paddr_in == plsc_pkg::REG_SPEC_ADDR;
  assign wr_modes = ce_in && access && apb_pwrite_in && apb_paddr_in == plsc_pkg::REG_MODES_ADDR;
  // zero wait states; pready held low while ce is low so no write is lost
  assign apb_pready_out  = access && ce_in;
  assign apb_pslverr_out = access && ce_in && !hit;
  assign apb_prdata_out  = prdata_reg;

  // configuration sequence: hold pins, capture straps, run, soft reset
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg    <= ST_HOLD;
      srst_cnt_reg <= 10'h000;
    end else if (ce_in) begin
      unique case (state_reg)
        ST_HOLD: begin
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (wr_ctrl && apb_pwdata_in[plsc_pkg::CTRL_SRST_BIT]) begin
            state_reg    <= ST_SRST;
            srst_cnt_reg <= 10'(SRST_CYCLES - 1);
          end
        end
        ST_SRST: begin
          // a new write of bit 15 in the final cycle restarts the count, though the presets still load
          if (wr_ctrl && apb_pwdata_in[plsc_pkg::CTRL_SRST_BIT]) begin
            srst_cnt_reg <= 10'(SRST_CYCLES - 1);
          end else if (srst_cnt_reg == 10'h000) begin
            state_reg <= ST_RUN;
          end else begin
            srst_cnt_reg <= srst_cnt_reg - 10'h001;
          end
        end
      endcase
    end
  end

  // address and mode field, kept across soft reset
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode_reg <= 3'h0;
      addr_reg <= 5'h00;
    end else if (capture) begin
      mode_reg <= strap_mode;
      addr_reg <= {4'h0, addr_strap_bit_in};
    end else if (wr_modes) begin
      mode_reg <= apb_pwdata_in[plsc_pkg::MODES_MODE_LSB +: 3];
      addr_reg <= apb_pwdata_in[plsc_pkg::MODES_ADDR_LSB +: 5];
    end
  end

  // control and advertisement bits: presets on load, else software writes
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      {loop_reg, speed_reg, an_reg, pdown_reg, iso_reg, duplex_reg, coltest_reg} <= 7'h00;
      adv_reg <= plsc_pkg::ADV_NONE_PRESET;
    end else if (load_evt) begin
      loop_reg    <= 1'b0;
      coltest_reg <= 1'b0;
      {speed_reg, an_reg, iso_reg, duplex_reg} <= pre_ctrl;
      pdown_reg   <= load_mode == plsc_pkg::MODE_PDOWN;
      adv_reg     <= plsc_pkg::preset_adv(load_mode);
    end else if (wr_ctrl) begin
      loop_reg    <= apb_pwdata_in[plsc_pkg::CTRL_LOOP_BIT];
      speed_reg   <= apb_pwdata_in[plsc_pkg::CTRL_SPEED_BIT];
      an_reg      <= apb_pwdata_in[plsc_pkg::CTRL_AN_BIT];
      pdown_reg   <= apb_pwdata_in[plsc_pkg::CTRL_PDOWN_BIT];
      iso_reg     <= apb_pwdata_in[plsc_pkg::CTRL_ISO_BIT];
      duplex_reg  <= apb_pwdata_in[plsc_pkg::CTRL_DUPLEX_BIT];
      coltest_reg <= apb_pwdata_in[plsc_pkg::CTRL_COLTEST_BIT];
    end else if (wr_adv) begin
      adv_reg <= apb_pwdata_in[plsc_pkg::ADV_LSB +: 4];
    end
  end

  // special control bits, cleared by either reset
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      far_reg    <= 1'b0;
      bypass_reg <= 1'b0;
    end else if (load_evt) begin
      far_reg    <= 1'b0;
      bypass_reg <= 1'b0;
    end else if (wr_spec) begin
      far_reg    <= apb_pwdata_in[plsc_pkg::SPEC_FAR_BIT];
      bypass_reg <= apb_pwdata_in[plsc_pkg::SPEC_BYPASS_BIT];
    end
  end

  // read data captured in the setup phase, stable through access
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata_reg <= 32'h0000_0000;
    end else if (ce_in && setup) begin
      prdata_reg <= 32'h0000_0000;
      unique case (apb_paddr_in)
        plsc_pkg::REG_CTRL_ADDR: begin
          prdata_reg[plsc_pkg::CTRL_SRST_BIT]    <= state_reg == ST_SRST;
          prdata_reg[plsc_pkg::CTRL_LOOP_BIT]    <= loop_reg;
          prdata_reg[plsc_pkg::CTRL_SPEED_BIT]   <= speed_reg;
          prdata_reg[plsc_pkg::CTRL_AN_BIT]      <= an_reg;
          prdata_reg[plsc_pkg::CTRL_PDOWN_BIT]   <= pdown_reg;
          prdata_reg[plsc_pkg::CTRL_ISO_BIT]     <= iso_reg;
          prdata_reg[plsc_pkg::CTRL_DUPLEX_BIT]  <= duplex_reg;
          prdata_reg[plsc_pkg::CTRL_COLTEST_BIT] <= coltest_reg;
        end
        plsc_pkg::REG_ADV_ADDR: begin
          prdata_reg[plsc_pkg::ADV_LSB +: 4] <= adv_reg;
        end
        plsc_pkg::REG_SPEC_ADDR: begin
          prdata_reg[plsc_pkg::SPEC_FAR_BIT]    <= far_reg;
          prdata_reg[plsc_pkg::SPEC_BYPASS_BIT] <= bypass_reg;
        end
        plsc_pkg::REG_MODES_ADDR: begin
          prdata_reg[plsc_pkg::MODES_MODE_LSB +: 3] <= mode_reg;
          prdata_reg[plsc_pkg::MODES_ADDR_LSB +: 5] <= addr_reg;
        end
        default: begin
          prdata_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  // address match, with write bypass; reads always need a match
  assign mgmt_accept_out = mgmt_valid_in && (mgmt_addr_in == addr_reg ||
                           (mgmt_write_in && bypass_reg));
  assign phy_addr_out    = addr_reg;
  assign pdown_out       = pdown_reg;

  // loopback selection; far loopback wins if both are set
  assign far_act     = far_reg && !pdown_reg && state_reg != ST_HOLD;
  assign near_act    = loop_reg && !far_reg && !pdown_reg && state_reg != ST_HOLD;
  assign mac_quiet   = far_act || pdown_reg || iso_reg || state_reg == ST_HOLD;
  assign txd_eff     = mac_quiet ? 2'h0 : mac_txd_in;
  assign tx_en_eff   = mac_tx_en_in && !mac_quiet;
  // repeater and full duplex keep carrier on receive activity only
  assign half_tx_crs = !duplex_reg && mode_reg != plsc_pkg::MODE_REPEATER && tx_en_eff;

  // transmit scrambler, reseeded from the address at every load
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lfsr_reg <= {plsc_pkg::SCR_SEED_HI, 5'h00};
    end else if (load_evt) begin
      lfsr_reg <= {plsc_pkg::SCR_SEED_HI, capture ? {4'h0, addr_strap_bit_in} : addr_reg};
    end else if (ce_in) begin
      lfsr_reg <= {lfsr_reg[9:0], lfsr_reg[10] ^ lfsr_reg[8]};
    end
  end

  // coding stage: scrambled symbol with its key for the near loop
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scr_data_reg <= 2'h0;
      key_reg      <= 2'h0;
      tx_en_q_reg  <= 1'b0;
    end else if (ce_in) begin
      scr_data_reg <= txd_eff ^ lfsr_reg[1:0];
      key_reg      <= lfsr_reg[1:0];
      tx_en_q_reg  <= tx_en_eff;
    end
  end

  // line side: echo in far loop, transmitters off in near loop
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      line_txd_out   <= 2'h0;
      line_tx_en_out <= 1'b0;
    end else if (ce_in) begin
      if (far_act) begin
        line_txd_out   <= line_rxd_in;
        line_tx_en_out <= line_rx_dv_in;
      end else begin
        line_txd_out   <= (near_act || pdown_reg) ? 2'h0 : scr_data_reg;
        line_tx_en_out <= tx_en_q_reg && !near_act && !pdown_reg;
      end
    end
  end

  // mac receive side; quiet in far loop, power down and before capture
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rxd_out    <= 2'h0;
      crs_dv_out <= 1'b0;
      rx_er_out  <= 1'b0;
      col_out    <= 1'b0;
    end else if (ce_in) begin
      if (far_act || pdown_reg || state_reg == ST_HOLD) begin
        rxd_out    <= 2'h0;
        crs_dv_out <= 1'b0;
        rx_er_out  <= 1'b0;
        col_out    <= 1'b0;
      end else if (near_act) begin
        rxd_out    <= scr_data_reg ^ key_reg;
        crs_dv_out <= tx_en_q_reg;
        rx_er_out  <= 1'b0;
        col_out    <= coltest_reg && tx_en_eff;
      end else begin
        rxd_out    <= line_rxd_in;
        crs_dv_out <= line_rx_dv_in || half_tx_crs;
        rx_er_out  <= line_rx_er_in;
        col_out    <= !duplex_reg && tx_en_eff && (line_rx_dv_in || coltest_reg);
      end
    end
  end

  // shared pins float until straps are taken, so pulls set the level
  assign rxd_oe_out    = state_reg != ST_HOLD;
  assign crs_dv_oe_out = state_reg != ST_HOLD;
  assign rx_er_oe_out  = state_reg != ST_HOLD;

  property p_near_data;
    @(posedge clk_in) disable iff (!rst_n_reg)
    (ce_in && near_act)[*2] |=> rxd_out == $past(txd_eff, 2);
  endproperty
  a_near_data: assert property (p_near_data) else $error("near loop data mismatch");

  property p_near_col;
    @(posedge clk_in) disable iff (!rst_n_reg)
    ce_in && near_act && !coltest_reg |=> !col_out;
  endproperty
  a_near_col: assert property (p_near_col) else $error("collision in near loop");

  property p_near_txoff;
    @(posedge clk_in) disable iff (!rst_n_reg)
    ce_in && near_act |=> !line_tx_en_out;
  endproperty
  a_near_txoff: assert property (p_near_txoff) else $error("transmitter on in near loop");

  property p_far_echo;
    @(posedge clk_in) disable iff (!rst_n_reg)
    ce_in && far_act |=> line_txd_out == $past(line_rxd_in) && line_tx_en_out == $past(line_rx_dv_in);
  endproperty
  a_far_echo: assert property (p_far_echo) else $error("far loop echo wrong");

  property p_far_iso;
    @(posedge clk_in) disable iff (!rst_n_reg)
    ce_in && far_act |=> rxd_out == 2'h0 && !crs_dv_out && !col_out;
  endproperty
  a_far_iso: assert property (p_far_iso) else $error("mac side active in far loop");

  property p_strap_load;
    @(posedge clk_in) disable iff (!rst_n_reg)
    $past(capture) |-> addr_reg == {4'h0, $past(addr_strap_bit_in)} && mode_reg == $past(strap_mode)
      && {speed_reg, an_reg, iso_reg, duplex_reg} == plsc_pkg::preset_ctrl($past(strap_mode));
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap capture wrong");

  property p_accept;
    @(posedge clk_in) disable iff (!rst_n_reg)
    mgmt_valid_in && mgmt_addr_in != addr_reg && (!mgmt_write_in || !bypass_reg) |-> !mgmt_accept_out;
  endproperty
  a_accept: assert property (p_accept) else $error("foreign frame accepted");

  property p_seed;
    @(posedge clk_in) disable iff (!rst_n_reg)
    $past(load_evt) |-> lfsr_reg == {plsc_pkg::SCR_SEED_HI, addr_reg};
  endproperty
  a_seed: assert property (p_seed) else $error("scrambler not seeded by address");

  property p_srst_clear;
    @(posedge clk_in) disable iff (!rst_n_reg)
    srst_done && !wr_ctrl |=> state_reg == ST_RUN ##0 mode_reg == $past(mode_reg) && !far_reg;
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset did not finish");

  property p_pins_free;
    @(posedge clk_in) disable iff (!rst_n_reg)
    state_reg == ST_HOLD |-> !rxd_oe_out && !crs_dv_oe_out && !rx_er_oe_out;
  endproperty
  a_pins_free: assert property (p_pins_free) else $error("strap pin driven during capture");

  c_near: cover property (@(posedge clk_in) disable iff (!rst_n_reg) near_act && tx_en_q_reg);
  c_far: cover property (@(posedge clk_in) disable iff (!rst_n_reg) far_act && line_rx_dv_in);
  c_srst: cover property (@(posedge clk_in) disable iff (!rst_n_reg) srst_done);
  c_bypass: cover property (@(posedge clk_in) disable iff (!rst_n_reg)
                            mgmt_accept_out && mgmt_addr_in != addr_reg);

endmodule // plsc_phy_cfg

/* testbench/plsc_mac_model.sv */
// mac transmit source facing the phy block.
// assumes the bench raises en_in only after reset.
`timescale 1ns/1ps
module plsc_mac_model (
  input  wire logic       clk_in,      // core clock
  input  wire logic       en_in,       // start sending
  output logic      [1:0] txd_out,     // transmit data toward the phy
  output logic            tx_en_out    // transmit enable toward the phy
);
  // counting dibits so a delay slip shows; idle flips the last value
  initial begin
    txd_out   = 2'h0;
    tx_en_out = 1'b0;
    forever begin
      @(posedge clk_in);
      tx_en_out <= en_in;
      txd_out   <= en_in ? txd_out + 2'h1 : ~txd_out;
    end
  end
endmodule // plsc_mac_model

/* testbench/plsc_phy_cfg_tb.sv */
// bench for the loopback and strap block, apb master plus strap pulls.
// assumes plsc_pkg and the mac model are compiled first.
`timescale 1ns/1ps
module plsc_phy_cfg_tb;
  logic clk_in = 0, rstn_in = 0, ce_in = 1, tx_go = 0, rd_err, addr_strap = 1;
  logic apb_psel_in = 0, apb_penable_in = 0, apb_pwrite_in = 0, apb_pready_out, apb_pslverr_out;
  logic [7:0] apb_paddr_in = 8'h00;
  logic [31:0] apb_pwdata_in = 32'h0, apb_prdata_out, rd;
  logic [1:0] rxd_out, mac_txd_in, line_txd_out, line_rxd_in = 2'h2, v;
  logic rxd_oe_out, crs_dv_out, crs_dv_oe_out, rx_er_out, rx_er_oe_out, col_out, mac_tx_en_in;
  logic line_rx_dv_in = 1, line_rx_er_in = 0, line_tx_en_out, mgmt_valid_in = 0, mgmt_write_in = 0;
  logic mgmt_accept_out, pdown_out;
  logic [4:0] mgmt_addr_in = 5'h00, phy_addr_out;
  logic [2:0] mode_strap = 3'h7;
  int fail_count = 0, comparisons = 0;
  // pull levels show only while the phy leaves the shared pins undriven
  wire [1:0] rxd_in = rxd_oe_out ? rxd_out : mode_strap[1:0];
  wire crs_dv_in = crs_dv_oe_out ? crs_dv_out : mode_strap[2];
  wire addr_strap_bit_in = rx_er_oe_out ? rx_er_out : addr_strap;
  plsc_phy_cfg #(.SRST_CYCLES(3)) dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .apb_psel_in(apb_psel_in),
    .apb_penable_in(apb_penable_in), .apb_pwrite_in(apb_pwrite_in), .apb_paddr_in(apb_paddr_in),
    .apb_pwdata_in(apb_pwdata_in), .apb_prdata_out(apb_prdata_out), .apb_pready_out(apb_pready_out),
    .apb_pslverr_out(apb_pslverr_out), .mac_txd_in(mac_txd_in), .mac_tx_en_in(mac_tx_en_in),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_out(rxd_oe_out), .crs_dv_in(crs_dv_in),
    .crs_dv_out(crs_dv_out), .crs_dv_oe_out(crs_dv_oe_out), .addr_strap_bit_in(addr_strap_bit_in),
    .rx_er_out(rx_er_out), .rx_er_oe_out(rx_er_oe_out), .col_out(col_out), .line_rxd_in(line_rxd_in),
    .line_rx_dv_in(line_rx_dv_in), .line_rx_er_in(line_rx_er_in), .line_txd_out(line_txd_out),
    .line_tx_en_out(line_tx_en_out), .mgmt_valid_in(mgmt_valid_in), .mgmt_addr_in(mgmt_addr_in),
    .mgmt_write_in(mgmt_write_in), .mgmt_accept_out(mgmt_accept_out), .phy_addr_out(phy_addr_out),
    .pdown_out(pdown_out));
  plsc_mac_model mac_u (.clk_in(clk_in), .en_in(tx_go), .txd_out(mac_txd_in), .tx_en_out(mac_tx_en_in));
  always #20 clk_in = ~clk_in;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, waits for pready whatever the latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    apb_psel_in <= 1;
    apb_pwrite_in <= w;
    apb_paddr_in <= a;
    apb_pwdata_in <= d;
    @(posedge clk_in);
    apb_penable_in <= 1;
    do @(posedge clk_in); while (apb_pready_out !== 1'b1);
    rd = apb_prdata_out;
    rd_err = apb_pslverr_out;
    apb_psel_in <= 0;
    apb_penable_in <= 0;
  endtask
  task mg(input logic [4:0] a, input logic w, input logic e);
    @(posedge clk_in);
    mgmt_valid_in <= 1;
    mgmt_addr_in <= a;
    mgmt_write_in <= w;
    @(posedge clk_in);
    #1 chk("accept", mgmt_accept_out, e);
  endtask
  task soft_reset;
    apb(1, plsc_pkg::REG_CTRL_ADDR, 32'h8000);
    do apb(0, plsc_pkg::REG_CTRL_ADDR, 32'h0); while (rd[15] !== 1'b0);
  endtask
  task t_strap;
    chk("pin_oe", {rxd_oe_out, crs_dv_oe_out, rx_er_oe_out}, 32'h7);
    chk("phy_addr", phy_addr_out, 32'h1);
    apb(0, plsc_pkg::REG_CTRL_ADDR, 32'h0);
    chk("ctrl", rd, 32'h3100);
    apb(0, plsc_pkg::REG_ADV_ADDR, 32'h0);
    chk("adv", rd, 32'h1e0);
    apb(0, 8'h08, 32'h0);
    chk("slverr", rd_err, 32'h1);
    mg(5'h01, 0, 1);
    mg(5'h02, 1, 0);
    apb(1, plsc_pkg::REG_SPEC_ADDR, 32'h8);
    mg(5'h02, 1, 1);
    mg(5'h02, 0, 0);
  endtask
  task t_loop;
    @(posedge clk_in);
    tx_go <= 1;
    apb(1, plsc_pkg::REG_CTRL_ADDR, 32'h7100);
    @(posedge clk_in);
    #1 v = mac_txd_in;
    repeat (2) @(posedge clk_in);
    #1 chk("near_rxd", rxd_out, v);
    chk("line_tx_en", line_tx_en_out, 32'h0);
    chk("col", col_out, 32'h0);
    apb(1, plsc_pkg::REG_CTRL_ADDR, 32'h7180);
    repeat (2) @(posedge clk_in);
    #1 chk("col_test", col_out, 32'h1);
    apb(1, plsc_pkg::REG_SPEC_ADDR, 32'h200);
    line_rxd_in <= 2'h1;
    @(posedge clk_in);
    #1 chk("far_txd", line_txd_out, 32'h1);
    chk("mac_quiet", {rxd_out, crs_dv_out, col_out}, 32'h0);
  endtask
  // soft reset into one fixed speed and duplex code
  task t_fixed(input logic [2:0] m, input logic [31:0] e);
    apb(1, plsc_pkg::REG_MODES_ADDR, {24'h0, m, 5'h05});
    soft_reset();
    chk("ctrl_fixed", rd, e);
  endtask
  task t_modes;
    apb(1, plsc_pkg::REG_MODES_ADDR, 32'h85);
    #1 chk("new_addr", phy_addr_out, 32'h5);
    mg(5'h05, 0, 1);
    soft_reset();
    chk("ctrl_srst", rd, 32'h3000);
    apb(0, plsc_pkg::REG_ADV_ADDR, 32'h0);
    chk("adv_srst", rd, 32'h80);
    line_rx_dv_in <= 0;
    repeat (2) @(posedge clk_in);
    #1 chk("crs_half", crs_dv_out, 32'h1);
    apb(1, plsc_pkg::REG_MODES_ADDR, 32'ha5);
    soft_reset();
    chk("ctrl_rep", rd, 32'h3000);
    #1 chk("crs_rep", crs_dv_out, 32'h0);
    apb(1, plsc_pkg::REG_MODES_ADDR, 32'hc5);
    soft_reset();
    chk("pdown", pdown_out, 32'h1);
    apb(1, plsc_pkg::REG_MODES_ADDR, 32'h85);
    soft_reset();
    chk("wake", pdown_out, 32'h0);
    t_fixed(3'h0, 32'h0000);
    t_fixed(3'h1, 32'h0100);
    t_fixed(3'h2, 32'h2000);
    t_fixed(3'h3, 32'h2100);
  endtask
  // mid-run hardware reset with new straps; ce low must hold off capture
  task t_hwreset;
    @(posedge clk_in);
    rstn_in <= 0;
    ce_in <= 0;
    mode_strap <= 3'h3;
    addr_strap <= 0;
    repeat (8) @(posedge clk_in); // scaled reset hold
    rstn_in <= 1;
    repeat (4) @(posedge clk_in);
    chk("ce_hold", {rxd_oe_out, crs_dv_oe_out, rx_er_oe_out}, 32'h0);
    ce_in <= 1;
    repeat (2) @(posedge clk_in);
    chk("hw_addr", phy_addr_out, 32'h0);
    apb(0, plsc_pkg::REG_CTRL_ADDR, 32'h0);
    chk("hw_ctrl", rd, 32'h2100);
    line_rx_er_in <= 1;
    @(posedge clk_in);
    #1 chk("rx_er", rx_er_out, 32'h1);
    chk("crs_full", crs_dv_out, 32'h0);
  endtask
  task summarize;
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_in); // scaled reset hold
    chk("oe_rst", {rxd_oe_out, crs_dv_oe_out, rx_er_oe_out}, 32'h0);
    rstn_in <= 1;
    repeat (4) @(posedge clk_in);
    t_strap();
    t_loop();
    t_modes();
    t_hwreset();
    summarize();
  end
  // hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule // plsc_phy_cfg_tb
